// File: design/stfa_top.sv
// Purpose: Sorts self-test results, drives alarms, lamp, display and status query
// Assumes: Fault, key and system inputs come from logic on clk
// Notes:   Registers reached over AXI4-Lite, one outstanding write and read
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: Memory check failures critical with restart
// R2: Acquisition timer critical, support timer noncritical
// R3: Input optocoupler mismatch warns, pilot off
// R4: Loop-back restarts; trip, converter critical; panel warns
// R5: Critical failure opens alarm, lamp red
// R6: Clean restart returns lamp to green
// R7: Fail code shown until key or restart
// R8: Noncritical closes alarm, lamp stays green
// R9: Warn code shown until key or restart
// R10: Summary categories map to alarms and lamp
// R11: Acquisition board failure codes
// R12: Signal processor board failure codes
// R13: Analog input and magnetics failure codes
// R14: Support processor failure codes
// R15: Front panel output failure code
// R16: Input, timer, capture, clock warning codes
// R17: Serial port and display warning codes
// R18: Analog output, strobe, logon warning codes
// R19: Long outage presets clock, clears records
// R20: Query local or remote, summary then detail
// R21: System status drives outputs without message
// R22: Failure display outranks warning display
// R23: Codes clear on reset, reload from tests
module stfa_top (
   input  wire logic [stfa_pkg::NUM_FAULTS-1:0] faultIn,
   input  wire logic                            clk,
   input  wire logic                            sys_rst,
   input  wire stfa_pkg::stfa_keys_t            keys,
   input  wire stfa_pkg::stfa_sysin_t           sysIn,
   input  wire stfa_pkg::stfa_axi_req_t         axiReq,
   output wire stfa_pkg::stfa_axi_rsp_t         axiRsp,
   output wire stfa_pkg::stfa_annun_t           annun,
   output wire stfa_pkg::stfa_disp_t            disp
);
   stfa_pkg::stfa_state_t s_q;
   stfa_pkg::stfa_state_t s_d;

   assign axiRsp = s_q.axiRsp;
   assign annun  = s_q.annun;
   assign disp   = s_q.disp;

   always_comb begin
      logic                   failHit;
      logic                   warnHit;
      logic                   restartHit;
      logic                   pilotHit;
      logic [11:0]            fCode;
      logic [11:0]            wCode;
      logic                   remSum;
      logic                   remDet;
      logic                   remDismiss;
      logic                   sumReq;
      logic                   detReq;
      logic                   dismiss;
      logic                   sysFail;
      stfa_pkg::stfa_status_t st;
      stfa_pkg::stfa_codes_t  cw;
      stfa_pkg::stfa_qword_t  qw;
      failHit    = 1'h0;
      warnHit    = 1'h0;
      restartHit = 1'h0;
      pilotHit   = 1'h0;
      fCode      = 12'h000;
      wCode      = 12'h000;
      remSum     = 1'h0;
      remDet     = 1'h0;
      remDismiss = 1'h0;
      sumReq     = 1'h0;
      detReq     = 1'h0;
      dismiss    = 1'h0;
      sysFail    = 1'h0;
      st         = stfa_pkg::stfa_status_t'(0);
      cw         = stfa_pkg::stfa_codes_t'(0);
      qw         = stfa_pkg::stfa_qword_t'(0);
      s_d        = s_q;
      s_d.annun.restartReq = 1'h0;
      s_d.annun.rtcLoad    = 1'h0;
      s_d.annun.clearRec   = 1'h0;

      // Outage flag is sampled once, on the first edge after reset release
      if (!s_q.pwrChecked) begin
         s_d.pwrChecked = 1'h1;
         if (sysIn.powerLost) begin
            s_d.annun.rtcLoad  = 1'h1; // R19
            s_d.annun.clearRec = 1'h1; // R19
         end
      end

      // AXI write channels, taken in either order
      if (s_q.axiRsp.awready && axiReq.awvalid) begin
         s_d.awHave = 1'h1;
         s_d.awAddr = axiReq.awaddr;
      end
      if (s_q.axiRsp.wready && axiReq.wvalid) begin
         s_d.wHave = 1'h1;
         s_d.wData = axiReq.wdata;
         s_d.wStrb = axiReq.wstrb;
      end
      if (s_q.axiRsp.bvalid && axiReq.bready) begin
         s_d.axiRsp.bvalid = 1'h0;
      end
      if (s_q.awHave && s_q.wHave && !s_q.axiRsp.bvalid) begin
         s_d.awHave        = 1'h0;
         s_d.wHave         = 1'h0;
         s_d.axiRsp.bvalid = 1'h1;
         if (s_q.awAddr == stfa_pkg::REG_QUERY) begin
            s_d.axiRsp.bresp = stfa_pkg::RESP_OKAY;
            if (s_q.wStrb[0]) begin
               remSum     = s_q.wData[stfa_pkg::Q_SUM_BIT];
               remDet     = s_q.wData[stfa_pkg::Q_DET_BIT];
               remDismiss = s_q.wData[stfa_pkg::Q_DISMISS_BIT];
            end
         end else if (s_q.awAddr == stfa_pkg::REG_STATUS || s_q.awAddr == stfa_pkg::REG_CODES) begin
            // Read-only words accept and ignore the data
            s_d.axiRsp.bresp = stfa_pkg::RESP_OKAY;
         end else begin
            s_d.axiRsp.bresp = stfa_pkg::RESP_SLVERR;
         end
      end
      s_d.axiRsp.awready = !s_d.awHave && !s_d.axiRsp.bvalid;
      s_d.axiRsp.wready  = !s_d.wHave && !s_d.axiRsp.bvalid;

      // Status query, local keypad or remote link alike
      sumReq  = keys.status || remSum; // R20
      detReq  = keys.up || remDet; // R20
      dismiss = keys.other || remDismiss;
      case (s_q.qStage)
         stfa_pkg::Q_IDLE: begin
            if (sumReq) begin
               s_d.qStage = stfa_pkg::Q_SUM; // R20
            end else if (dismiss) begin
               s_d.dispShow = 1'h0; // R7 R9
            end
         end
         stfa_pkg::Q_SUM: begin
            if (detReq) begin
               s_d.qStage = stfa_pkg::Q_DET; // R20
            end else if (dismiss) begin
               s_d.qStage = stfa_pkg::Q_IDLE;
            end
         end
         stfa_pkg::Q_DET: begin
            if (dismiss) begin
               s_d.qStage = stfa_pkg::Q_IDLE;
            end
         end
         default: begin
            s_d.qStage = stfa_pkg::Q_IDLE;
         end
      endcase

      // Scan downward so the lowest index is the one kept
      for (int i = stfa_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
         if (faultIn[i]) begin
            if (stfa_pkg::FAULT_TABLE[i].crit) begin
               failHit = 1'h1;
               fCode   = stfa_pkg::FAULT_TABLE[i].code; // R11 R12 R13 R14 R15
            end else begin
               warnHit = 1'h1;
               wCode   = stfa_pkg::FAULT_TABLE[i].code; // R16 R17 R18
            end
            restartHit = restartHit | stfa_pkg::FAULT_TABLE[i].restart;
            pilotHit   = pilotHit | stfa_pkg::FAULT_TABLE[i].pilotOff;
         end
      end
      // First cause of each class is kept until reset; a new one beats a dismiss
      if (failHit && !s_q.failLatched) begin
         s_d.failLatched = 1'h1; // R23
         s_d.failCode    = fCode; // R7
         s_d.dispShow    = 1'h1; // R7
      end
      if (warnHit && !s_q.warnLatched) begin
         s_d.warnLatched = 1'h1; // R23
         s_d.warnCode    = wCode; // R9
         s_d.dispShow    = 1'h1; // R9
      end
      s_d.annun.restartReq = restartHit; // R1 R4
      if (pilotHit) begin
         s_d.annun.pilotOff = 1'h1; // R3
      end
      if (s_q.phase == stfa_pkg::PH_START && sysIn.startupDone) begin
         s_d.phase = stfa_pkg::PH_RUN;
      end

      // Lamp stays red through start-up so a board that never finishes is visible
      sysFail = s_d.failLatched || sysIn.tripOpen; // R4 R21
      s_d.annun.critOpen = sysFail; // R5 R10 R22
      s_d.annun.ncClosed = s_d.warnLatched; // R8 R10 R22
      s_d.annun.lampRed  = sysFail || sysIn.outsDisabled || sysIn.misc
                           || s_d.phase == stfa_pkg::PH_START; // R5 R6 R8 R10 R21

      if (s_d.qStage == stfa_pkg::Q_SUM) begin
         s_d.disp.kind = stfa_pkg::DK_SUMMARY;
         s_d.disp.code = {9'h000, sysIn.outsDisabled || sysIn.misc, sysFail, s_d.warnLatched}; // R10 R20
      end else if (s_d.qStage == stfa_pkg::Q_DET) begin
         s_d.disp.kind = stfa_pkg::DK_DETAIL;
         s_d.disp.code = s_d.failLatched ? s_d.failCode : s_d.warnCode; // R20
      end else if (s_d.dispShow && s_d.failLatched) begin
         s_d.disp.kind = stfa_pkg::DK_FAIL; // R7 R22
         s_d.disp.code = s_d.failCode;
      end else if (s_d.dispShow && s_d.warnLatched) begin
         s_d.disp.kind = stfa_pkg::DK_WARN; // R9
         s_d.disp.code = s_d.warnCode;
      end else begin
         // Trip circuit or disabled outputs alone bring no message
         s_d.disp.kind = stfa_pkg::DK_NONE; // R21
         s_d.disp.code = 12'h000;
      end

      // AXI read channel, answered on the same edge that takes the address
      st.fail     = s_q.failLatched || sysIn.tripOpen;
      st.warn     = s_q.warnLatched;
      st.misc     = sysIn.outsDisabled || sysIn.misc;
      st.lampRed  = s_q.annun.lampRed;
      st.critOpen = s_q.annun.critOpen;
      st.ncClosed = s_q.annun.ncClosed;
      st.pilotOff = s_q.annun.pilotOff;
      st.startup  = s_q.phase == stfa_pkg::PH_START;
      cw.fail     = s_q.failCode;
      cw.warn     = s_q.warnCode;
      qw.stage    = s_q.qStage;
      qw.kind     = s_q.disp.kind;
      qw.code     = s_q.disp.code;
      if (s_q.axiRsp.rvalid && axiReq.rready) begin
         s_d.axiRsp.rvalid = 1'h0;
      end
      if (s_q.axiRsp.arready && axiReq.arvalid) begin
         s_d.axiRsp.rvalid = 1'h1;
         s_d.axiRsp.rresp  = stfa_pkg::RESP_OKAY;
         if (axiReq.araddr == stfa_pkg::REG_STATUS) begin
            s_d.axiRsp.rdata = st;
         end else if (axiReq.araddr == stfa_pkg::REG_CODES) begin
            s_d.axiRsp.rdata = cw;
         end else if (axiReq.araddr == stfa_pkg::REG_QUERY) begin
            s_d.axiRsp.rdata = qw;
         end else begin
            s_d.axiRsp.rdata = 32'h0000_0000;
            s_d.axiRsp.rresp = stfa_pkg::RESP_SLVERR;
         end
      end
      s_d.axiRsp.arready = !s_d.axiRsp.rvalid;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= stfa_pkg::STATE_RESET; // R23
      end else begin
         s_q <= s_d;
      end
   end

   localparam int WR_MAX = 2;

   default clocking dc @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence askSummary;
      keys.status && s_q.qStage == stfa_pkg::Q_IDLE;
   endsequence
   sequence askDetail;
      keys.up && s_q.qStage == stfa_pkg::Q_SUM;
   endsequence
   sequence noDismiss;
      !keys.other && !keys.status && !(s_q.awHave && s_q.wHave);
   endsequence

   critAlarm_a: assert property ($rose(s_q.failLatched) |-> annun.critOpen && annun.lampRed) // R5
      else $error("critical latch without open alarm and red lamp");
   firstCause_a: assert property (faultIn[stfa_pkg::F_ACQ_PROM] && !s_q.failLatched |=>
      s_q.failCode == stfa_pkg::FAULT_TABLE[stfa_pkg::F_ACQ_PROM].code && annun.restartReq) // R1
      else $error("memory failure code or restart missing");
   acqTimer_a: assert property (faultIn[stfa_pkg::F_ACQ_TIMER] |=>
      s_q.failLatched && annun.restartReq) // R2
      else $error("acquisition timer failure not critical");
   sspTimer_a: assert property (faultIn[stfa_pkg::F_SSP_TIMER] && !s_q.warnLatched
      && faultIn[stfa_pkg::F_DIG_IN] == 1'h0 |=>
      s_q.warnLatched && s_q.warnCode == stfa_pkg::FAULT_TABLE[stfa_pkg::F_SSP_TIMER].code) // R2
      else $error("support timer warning not latched");
   pilotOff_a: assert property (faultIn[stfa_pkg::F_DIG_IN] |=>
      annun.pilotOff && s_q.warnLatched && annun.ncClosed) // R3
      else $error("input mismatch did not disable pilot");
   greenRun_a: assert property (s_q.phase == stfa_pkg::PH_RUN && !s_q.failLatched
      && !$past(sysIn.tripOpen) && !$past(sysIn.outsDisabled) && !$past(sysIn.misc)
      |-> !annun.lampRed && !annun.critOpen) // R6 R8
      else $error("lamp red without cause after clean start");
   failHold_a: assert property (disp.kind == stfa_pkg::DK_FAIL ##0 noDismiss |=>
      disp.kind == stfa_pkg::DK_FAIL && disp.code == s_q.failCode) // R7
      else $error("fail message dropped without key");
   precedence_a: assert property (s_q.failLatched && s_q.warnLatched && s_q.dispShow
      && s_q.qStage == stfa_pkg::Q_IDLE |-> disp.kind == stfa_pkg::DK_FAIL) // R22
      else $error("warning shown over failure");
   querySteps_a: assert property (askSummary |=> disp.kind == stfa_pkg::DK_SUMMARY
      ##0 askDetail |=> disp.kind == stfa_pkg::DK_DETAIL) // R20
      else $error("query did not step summary then detail");
   silentStatus_a: assert property (sysIn.tripOpen && !s_q.failLatched && faultIn == '0 |=>
      annun.critOpen && annun.lampRed && disp.kind != stfa_pkg::DK_FAIL) // R21
      else $error("trip circuit condition mishandled");
   miscLamp_a: assert property (sysIn.misc && !sysIn.tripOpen && !s_q.failLatched
      && faultIn == '0 |=> annun.lampRed && !annun.critOpen) // R10
      else $error("misc condition not lamp only");
   outage_a: assert property (!s_q.pwrChecked && sysIn.powerLost |=>
      annun.rtcLoad && annun.clearRec ##1 !annun.rtcLoad && !annun.clearRec) // R19
      else $error("outage preset not a single pulse");
   writeResp_a: assert property (s_q.awHave && s_q.wHave |-> ##[1:WR_MAX] axiRsp.bvalid)
      else $error("write response late");
endmodule // stfa_top
`default_nettype wire

// File: design/stfa_pkg.sv
// Purpose: Shared constants and types for the self-test fault annunciator
// Assumes: Self-test results arrive as same-clock pulses or levels
// Notes:   Codes are three BCD digits; the hundreds digit names the board
`default_nettype none
package stfa_pkg;
   localparam int NUM_FAULTS = 28;

   // Fault indices that other code refers to by name
   localparam int F_ACQ_PROM  = 0;
   localparam int F_ACQ_TIMER = 2;
   localparam int F_DIG_IN    = 17;
   localparam int F_SSP_TIMER = 18;

   typedef struct packed {
      logic [11:0] code;
      logic        crit;
      logic        restart;
      logic        pilotOff;
   } stfa_fault_t;

   // Class and code of each self-test result, lowest index wins a tie
   localparam stfa_fault_t FAULT_TABLE [NUM_FAULTS] = '{
      '{12'h100, 1'h1, 1'h1, 1'h0}, '{12'h102, 1'h1, 1'h1, 1'h0}, // R1 R11
      '{12'h106, 1'h1, 1'h1, 1'h0}, '{12'h124, 1'h1, 1'h0, 1'h0}, // R2 R11
      '{12'h207, 1'h1, 1'h1, 1'h0}, '{12'h209, 1'h1, 1'h1, 1'h0}, // R12
      '{12'h210, 1'h1, 1'h0, 1'h0}, '{12'h225, 1'h1, 1'h0, 1'h0}, // R12
      '{12'h311, 1'h1, 1'h0, 1'h0}, '{12'h312, 1'h1, 1'h0, 1'h0}, // R4 R13
      '{12'h313, 1'h1, 1'h0, 1'h0}, '{12'h414, 1'h1, 1'h0, 1'h0}, // R13
      '{12'h515, 1'h1, 1'h1, 1'h0}, '{12'h517, 1'h1, 1'h1, 1'h0}, // R14
      '{12'h520, 1'h1, 1'h1, 1'h0}, '{12'h523, 1'h1, 1'h0, 1'h0}, // R1 R14
      '{12'h621, 1'h1, 1'h1, 1'h0}, '{12'h235, 1'h0, 1'h0, 1'h1}, // R4 R15 R3 R16
      '{12'h537, 1'h0, 1'h0, 1'h0}, '{12'h538, 1'h0, 1'h0, 1'h0}, // R2 R16
      '{12'h539, 1'h0, 1'h0, 1'h0}, '{12'h640, 1'h0, 1'h0, 1'h0}, // R16 R17
      '{12'h641, 1'h0, 1'h0, 1'h0}, '{12'h643, 1'h0, 1'h0, 1'h0}, // R4 R17 R18
      '{12'h645, 1'h0, 1'h0, 1'h0}, '{12'h646, 1'h0, 1'h0, 1'h0}, // R17
      '{12'h742, 1'h0, 1'h0, 1'h0}, '{12'h844, 1'h0, 1'h0, 1'h0}  // R18
   };

   // Byte addresses of the registers
   localparam logic [31:0] REG_STATUS = 32'h0000_0000;
   localparam logic [31:0] REG_CODES  = 32'h0000_0004;
   localparam logic [31:0] REG_QUERY  = 32'h0000_0008;
   localparam int Q_SUM_BIT     = 0;
   localparam int Q_DET_BIT     = 1;
   localparam int Q_DISMISS_BIT = 2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Clock preset after a long outage, BCD hhmmss and mmddyy
   localparam int          HOLD_TIME_H  = 24;
   localparam logic [23:0] RTC_DEF_TIME = 24'h00_00_00;
   localparam logic [23:0] RTC_DEF_DATE = 24'h01_01_90;

   typedef enum logic {PH_START = 1'h0, PH_RUN = 1'h1} stfa_phase_t;
   typedef enum logic [1:0] {Q_IDLE = 2'h0, Q_SUM = 2'h1, Q_DET = 2'h3} stfa_query_t;
   typedef enum logic [2:0] {
      DK_NONE = 3'h0, DK_FAIL = 3'h1, DK_WARN = 3'h3, DK_SUMMARY = 3'h2, DK_DETAIL = 3'h6
   } stfa_dkind_t;

   typedef struct packed {logic status; logic up; logic other;} stfa_keys_t;
   typedef struct packed {
      logic tripOpen; logic outsDisabled; logic misc; logic startupDone; logic powerLost;
   } stfa_sysin_t;
   typedef struct packed {
      logic critOpen; logic ncClosed; logic lampRed; logic pilotOff;
      logic restartReq; logic rtcLoad; logic clearRec;
   } stfa_annun_t;
   typedef struct packed {stfa_dkind_t kind; logic [11:0] code;} stfa_disp_t;

   typedef struct packed {
      logic [31:0] awaddr; logic awvalid; logic [31:0] wdata; logic [3:0] wstrb; logic wvalid;
      logic bready; logic [31:0] araddr; logic arvalid; logic rready;
   } stfa_axi_req_t;
   typedef struct packed {
      logic awready; logic wready; logic [1:0] bresp; logic bvalid;
      logic arready; logic [31:0] rdata; logic [1:0] rresp; logic rvalid;
   } stfa_axi_rsp_t;

   // Read word layouts
   typedef struct packed {
      logic [23:0] rsvd; logic startup; logic pilotOff; logic ncClosed; logic critOpen;
      logic lampRed; logic misc; logic warn; logic fail;
   } stfa_status_t;
   typedef struct packed {
      logic [3:0] rsvdW; logic [11:0] warn; logic [3:0] rsvdF; logic [11:0] fail;
   } stfa_codes_t;
   typedef struct packed {
      logic [13:0] rsvd; stfa_query_t stage; logic rsvdK; stfa_dkind_t kind; logic [11:0] code;
   } stfa_qword_t;

   typedef struct packed {
      stfa_phase_t   phase;
      logic          pwrChecked;
      logic          failLatched;
      logic [11:0]   failCode;
      logic          warnLatched;
      logic [11:0]   warnCode;
      logic          dispShow;
      stfa_query_t   qStage;
      stfa_annun_t   annun;
      stfa_disp_t    disp;
      logic          awHave;
      logic [31:0]   awAddr;
      logic          wHave;
      logic [31:0]   wData;
      logic [3:0]    wStrb;
      stfa_axi_rsp_t axiRsp;
   } stfa_state_t;

   localparam stfa_state_t STATE_RESET = stfa_state_t'(0);
endpackage
`default_nettype wire

// File: test/stfa_panel_model.sv
// Purpose: Front-panel keypad stand-in, one key pulse per request
// Assumes: Requests come on clk, one at a time
// Notes:   Slow mode waits nine cycles, like a hesitant operator
`timescale 1ns/1ps
`default_nettype none
module stfa_panel_model (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic [1:0]           cmd,
   input  wire logic                 go,
   input  wire logic                 slow,
   output var  stfa_pkg::stfa_keys_t keys,
   output var  logic                 sent
);
   logic       busy_q;
   logic [1:0] cmd_q;
   logic [3:0] wait_q;
   logic       fire;
   assign fire = !sys_rst && busy_q && wait_q == 4'h0;
   // Keys last one cycle, so one press is never seen twice
   always_ff @(posedge clk) begin
      sent        <= fire;
      keys.status <= fire && cmd_q == 2'h1;
      keys.up     <= fire && cmd_q == 2'h2;
      keys.other  <= fire && cmd_q == 2'h3;
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else if (go && !busy_q) begin
         busy_q <= 1'b1;
         cmd_q  <= cmd;
         wait_q <= slow ? 4'h9 : 4'h0;
      end else if (busy_q && wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
         busy_q <= 1'b0;
      end
   end
endmodule // stfa_panel_model
`default_nettype wire

// File: test/test_self_test_fault_annunciator.sv
// Purpose: Self-checking bench for the fault annunciator
// Assumes: Registers reached over AXI4-Lite, keys from the panel model
// Notes:   Each fault is tried alone after its own reset
`timescale 1ns/1ps
`default_nettype none
module test_self_test_fault_annunciator;
   localparam int CYC_LIMIT = 20000;
   localparam logic [11:0] CODE_TAB [28] = '{
      12'h100, 12'h102, 12'h106, 12'h124, 12'h207, 12'h209, 12'h210, 12'h225, 12'h311, 12'h312,
      12'h313, 12'h414, 12'h515, 12'h517, 12'h520, 12'h523, 12'h621, 12'h235, 12'h537, 12'h538,
      12'h539, 12'h640, 12'h641, 12'h643, 12'h645, 12'h646, 12'h742, 12'h844};
   localparam logic [27:0] RESTART_SET = 28'h0017037;
   logic                         clk;
   logic                         sys_rst;
   logic [27:0]                  faultIn;
   stfa_pkg::stfa_sysin_t        sysIn;
   stfa_pkg::stfa_axi_req_t      axiReq;
   wire stfa_pkg::stfa_axi_rsp_t axiRsp;
   wire stfa_pkg::stfa_annun_t   annun;
   wire stfa_pkg::stfa_disp_t    disp;
   wire stfa_pkg::stfa_keys_t    keys;
   wire logic                    sent;
   logic [1:0]                   cmd;
   logic                         go;
   logic                         slow;
   logic                         crit;
   logic [31:0]                  rd;
   logic [1:0]                   rsp;
   int                           n_errors;
   int                           num_checks;
   int                           cyc;

   stfa_top stfa_top_inst (.faultIn(faultIn), .clk(clk), .sys_rst(sys_rst), .keys(keys), .sysIn(sysIn),
      .axiReq(axiReq), .axiRsp(axiRsp), .annun(annun), .disp(disp));
   stfa_panel_model stfa_panel_model_inst (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .go(go), .slow(slow),
      .keys(keys), .sent(sent));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL t=%0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Master holds each channel until its own ready; only the cycle ceiling ends a wait
   task automatic axWrite(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      axiReq.awaddr <= a;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hf;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (axiReq.awvalid && axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
         if (axiReq.wvalid && axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
      end while (axiRsp.bvalid !== 1'b1);
      rsp = axiRsp.bresp;
      axiReq.bready <= 1'b0;
      chk({axiReq.awvalid, axiReq.wvalid}, 2'h0, "write channels taken before answer");
   endtask

   task automatic axRead(input logic [31:0] a);
      @(posedge clk);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (axiReq.arvalid && axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
      end while (axiRsp.rvalid !== 1'b1);
      rd = axiRsp.rdata;
      rsp = axiRsp.rresp;
      axiReq.rready <= 1'b0;
      chk(axiReq.arvalid, 1'b0, "address taken before data");
   endtask

   task automatic press(input logic [1:0] c, input logic s);
      @(posedge clk);
      cmd <= c;
      slow <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      while (sent !== 1'b1) begin
         @(posedge clk);
      end
      #1;
   endtask

   task automatic doRst(input logic pl);
      @(posedge clk);
      sys_rst <= 1'b1;
      faultIn <= '0;
      sysIn <= stfa_pkg::stfa_sysin_t'({4'h0, pl});
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(annun.rtcLoad, pl, "clock preset");
      chk(annun.clearRec, pl, "records cleared");
      chk(annun.lampRed, 1'b1, "lamp red in start-up");
      @(posedge clk);
      sysIn <= stfa_pkg::stfa_sysin_t'(5'h02);
      @(posedge clk);
      sysIn <= '0;
      @(posedge clk);
      #1;
      chk(annun.lampRed, 1'b0, "lamp green after clean start");
      axRead(stfa_pkg::REG_CODES);
      chk(rd, 32'h0, "codes cleared");
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc > CYC_LIMIT) begin
         n_errors++;
         close_out();
      end
   end

   initial begin
      sys_rst = 1'b1;
      faultIn = '0;
      sysIn = '0;
      axiReq = '0;
      cmd = 2'h0;
      go = 1'b0;
      slow = 1'b0;
      doRst(1'b1);
      for (int i = 0; i < stfa_pkg::NUM_FAULTS; i++) begin
         doRst(1'b0);
         @(posedge clk);
         faultIn[i] <= 1'b1;
         @(posedge clk);
         faultIn <= '0;
         #1;
         crit = (i < 17);
         chk(annun.critOpen, crit, "critical contact");
         chk(annun.ncClosed, !crit, "noncritical contact");
         chk(annun.lampRed, crit, "lamp colour");
         chk(annun.restartReq, RESTART_SET[i], "restart request");
         chk(annun.pilotOff, i == 17, "pilot off");
         chk(disp, {crit ? stfa_pkg::DK_FAIL : stfa_pkg::DK_WARN, CODE_TAB[i]}, "shown code");
         axRead(stfa_pkg::REG_CODES);
         chk(rd, crit ? {20'h0, CODE_TAB[i]} : {4'h0, CODE_TAB[i], 16'h0}, "latched code");
         $display("Test fault %0d done", i);
      end
      doRst(1'b0);
      @(posedge clk);
      faultIn[stfa_pkg::F_DIG_IN] <= 1'b1;
      @(posedge clk);
      faultIn <= 28'h0001000;
      @(posedge clk);
      faultIn <= '0;
      #1;
      chk(disp, {stfa_pkg::DK_FAIL, 12'h515}, "failure outranks warning");
      axRead(stfa_pkg::REG_STATUS);
      chk(rd, 32'h7b, "status word");
      axRead(stfa_pkg::REG_CODES);
      chk(rd, 32'h0235_0515, "both codes");
      press(2'h1, 1'b1);
      chk(disp, {stfa_pkg::DK_SUMMARY, 12'h003}, "local summary");
      press(2'h2, 1'b0);
      chk(disp, {stfa_pkg::DK_DETAIL, 12'h515}, "local detail");
      press(2'h3, 1'b0);
      press(2'h3, 1'b1);
      chk(disp.kind, stfa_pkg::DK_NONE, "dismissed");
      chk({annun.critOpen, annun.ncClosed}, 2'h3, "alarms held");
      axWrite(stfa_pkg::REG_QUERY, 32'h1);
      chk(rsp, stfa_pkg::RESP_OKAY, "query write");
      axRead(stfa_pkg::REG_QUERY);
      chk(rd, 32'h0001_2003, "remote summary");
      axWrite(stfa_pkg::REG_QUERY, 32'h2);
      axRead(stfa_pkg::REG_QUERY);
      chk(rd, 32'h0003_6515, "remote detail");
      axWrite(stfa_pkg::REG_QUERY, 32'h4);
      axRead(stfa_pkg::REG_QUERY);
      chk(rd, 32'h0, "remote dismiss");
      axWrite(32'h10, 32'h0);
      chk(rsp, stfa_pkg::RESP_SLVERR, "unmapped write");
      axRead(32'h10);
      chk({rsp, rd[29:0]}, {stfa_pkg::RESP_SLVERR, 30'h0}, "unmapped read");
      $display("Test precedence and query done");
      doRst(1'b0);
      @(posedge clk);
      sysIn <= stfa_pkg::stfa_sysin_t'(5'h10);
      repeat (2) @(posedge clk);
      #1;
      chk({annun.critOpen, annun.ncClosed, annun.lampRed}, 3'h5, "trip open");
      chk(disp.kind, stfa_pkg::DK_NONE, "no trip message");
      @(posedge clk);
      sysIn <= stfa_pkg::stfa_sysin_t'(5'h08);
      repeat (2) @(posedge clk);
      #1;
      chk({annun.critOpen, annun.ncClosed, annun.lampRed}, 3'h1, "outputs disabled");
      chk(disp.kind, stfa_pkg::DK_NONE, "no disable message");
      press(2'h1, 1'b0);
      chk(disp, {stfa_pkg::DK_SUMMARY, 12'h004}, "misc summary");
      @(posedge clk);
      sysIn <= stfa_pkg::stfa_sysin_t'(5'h04);
      repeat (2) @(posedge clk);
      #1;
      chk({annun.critOpen, annun.ncClosed, annun.lampRed}, 3'h1, "misc lamp only");
      $display("Test system status done");
      close_out();
   end
endmodule // test_self_test_fault_annunciator
`default_nettype wire
